/* File: rtl/icr_map.svh */
`ifndef ICR_MAP_SVH
`define ICR_MAP_SVH

// byte offsets on the register bus
`define ICR_OFF_NVEC      12'h100
`define ICR_OFF_FVEC      12'h104
`define ICR_OFF_PEND      12'h10C
`define ICR_OFF_MASK      12'h110
`define ICR_OFF_CORE      12'h114
`define ICR_OFF_EN        12'h120
`define ICR_OFF_DIS       12'h124
`define ICR_OFF_CLR       12'h128
`define ICR_OFF_SET       12'h12C
`define ICR_OFF_EOH       12'h130
`define ICR_OFF_SPU       12'h134
`define ICR_OFF_DBG       12'h138
`define ICR_OFF_FFEN      12'h140
`define ICR_OFF_FFDIS     12'h144
`define ICR_OFF_FFSTAT    12'h148

// field positions
`define ICR_BIT_FAST_SRC  0
`define ICR_BIT_SYS_SRC   1
`define ICR_BIT_FAST_LINE 0
`define ICR_BIT_NORM_LINE 1
`define ICR_BIT_PROTECTION_ENABLE      0
`define ICR_BIT_GLOBAL_LINE_MASK      1

// reset values and masks
`define ICR_SPU_RST       32'h0000_0000
`define ICR_DBG_RST       2'h0
`define ICR_SRC_RST       32'h0000_0000
`define ICR_FF_VALID      32'hFFFF_FFFE
`endif

/* File: rtl/icr_pkg.sv */
package icr_pkg;
    typedef enum logic [1:0] {
        icr_resp_okay   = 2'h0,
        icr_resp_slverr = 2'h2
    } icr_resp_t;
endpackage : icr_pkg

/* File: rtl/icr_top.sv */
`timescale 1ns/1ps
`include "icr_map.svh"
module icr_top #(
    parameter int AW = 12
) (
    // clock and reset
    input  wire logic          clk_i,
    input  wire logic          sys_rst_i,
    // axi4-lite write address and data
    input  wire logic [AW-1:0] s_axi_awaddr_i,
    input  wire logic          s_axi_awvalid_i,
    output logic               s_axi_awready_o,
    input  wire logic [31:0]   s_axi_wdata_i,
    input  wire logic [3:0]    s_axi_wstrb_i,
    input  wire logic          s_axi_wvalid_i,
    output logic               s_axi_wready_o,
    // axi4-lite write response
    output logic [1:0]         s_axi_bresp_o,
    output logic               s_axi_bvalid_o,
    input  wire logic          s_axi_bready_i,
    // axi4-lite read
    input  wire logic [AW-1:0] s_axi_araddr_i,
    input  wire logic          s_axi_arvalid_i,
    output logic               s_axi_arready_o,
    output logic [31:0]        s_axi_rdata_o,
    output logic [1:0]         s_axi_rresp_o,
    output logic               s_axi_rvalid_o,
    input  wire logic          s_axi_rready_i,
    // interrupt sources and vector block links
    input  wire logic [31:0]   src_level_i,
    input  wire logic [31:0]   normal_vector_i,
    input  wire logic [31:0]   fast_vector_i,
    // processor lines and side outputs
    output logic               fast_request_line_o,
    output logic               normal_request_line_o,
    output logic               end_of_handling_o,
    output logic               protection_enable_o
);

    function automatic logic hit(input logic [AW-1:0] a, input logic [11:0] off);
        return a[AW-1:2] == off[AW-1:2];
    endfunction : hit

    function automatic logic known(input logic [AW-1:0] a);
        return hit(a, `ICR_OFF_NVEC) | hit(a, `ICR_OFF_FVEC) | hit(a, `ICR_OFF_PEND) |
               hit(a, `ICR_OFF_MASK) | hit(a, `ICR_OFF_CORE) | hit(a, `ICR_OFF_EN) |
               hit(a, `ICR_OFF_DIS) | hit(a, `ICR_OFF_CLR) | hit(a, `ICR_OFF_SET) |
               hit(a, `ICR_OFF_EOH) | hit(a, `ICR_OFF_SPU) | hit(a, `ICR_OFF_DBG) |
               hit(a, `ICR_OFF_FFEN) | hit(a, `ICR_OFF_FFDIS) | hit(a, `ICR_OFF_FFSTAT);
    endfunction : known

    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{s[i]}};
        end
        return m;
    endfunction : strb_mask

    // ---------------- write channel state
    logic [AW-1:0] awaddr_r, awaddr_nxt;
    logic          aw_got_r, aw_got_nxt;
    logic [31:0]   wdata_r, wdata_nxt;
    logic [3:0]    wstrb_r, wstrb_nxt;
    logic          w_got_r, w_got_nxt;
    logic          awready_r, awready_nxt;
    logic          wready_r, wready_nxt;
    logic          bvalid_r, bvalid_nxt;
    logic [1:0]    bresp_r, bresp_nxt;
    logic          wr_do;
    logic [31:0]   wr_bits;
    logic          w_en, w_dis, w_clr, w_set, w_eoh, w_spu, w_dbg, w_ffen, w_ffdis, w_nvec;

    always_comb begin
        wr_do      = aw_got_r & w_got_r & ~bvalid_r;
        wr_bits    = wdata_r & strb_mask(wstrb_r);
        w_en       = wr_do & hit(awaddr_r, `ICR_OFF_EN);
        w_dis      = wr_do & hit(awaddr_r, `ICR_OFF_DIS);
        w_clr      = wr_do & hit(awaddr_r, `ICR_OFF_CLR);
        w_set      = wr_do & hit(awaddr_r, `ICR_OFF_SET);
        w_eoh      = wr_do & hit(awaddr_r, `ICR_OFF_EOH);
        w_spu      = wr_do & hit(awaddr_r, `ICR_OFF_SPU);
        w_dbg      = wr_do & hit(awaddr_r, `ICR_OFF_DBG);
        w_ffen     = wr_do & hit(awaddr_r, `ICR_OFF_FFEN);
        w_ffdis    = wr_do & hit(awaddr_r, `ICR_OFF_FFDIS);
        w_nvec     = wr_do & hit(awaddr_r, `ICR_OFF_NVEC);
        aw_got_nxt = (aw_got_r & ~wr_do) | (s_axi_awvalid_i & awready_r);
        w_got_nxt  = (w_got_r & ~wr_do) | (s_axi_wvalid_i & wready_r);
        awaddr_nxt = (s_axi_awvalid_i & awready_r) ? s_axi_awaddr_i : awaddr_r;
        wdata_nxt  = (s_axi_wvalid_i & wready_r) ? s_axi_wdata_i : wdata_r;
        wstrb_nxt  = (s_axi_wvalid_i & wready_r) ? s_axi_wstrb_i : wstrb_r;
        bvalid_nxt = wr_do | (bvalid_r & ~s_axi_bready_i);
        // one write in flight: both readies stay low until the response is taken
        awready_nxt = ~aw_got_nxt & ~bvalid_nxt;
        wready_nxt  = ~w_got_nxt & ~bvalid_nxt;
        bresp_nxt   = bresp_r;
        if (wr_do) begin
            bresp_nxt = known(awaddr_r) ? icr_pkg::icr_resp_okay : icr_pkg::icr_resp_slverr;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            awaddr_r  <= '0;
            aw_got_r  <= 1'b0;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
            w_got_r   <= 1'b0;
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= icr_pkg::icr_resp_okay;
        end else begin
            awaddr_r  <= awaddr_nxt;
            aw_got_r  <= aw_got_nxt;
            wdata_r   <= wdata_nxt;
            wstrb_r   <= wstrb_nxt;
            w_got_r   <= w_got_nxt;
            awready_r <= awready_nxt;
            wready_r  <= wready_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
        end
    end

    // ---------------- controller state
    logic [31:0] enable_r, enable_nxt;
    logic [31:0] pending_r, pending_nxt;
    logic [31:0] ffe_r, ffe_nxt;
    logic [31:0] spu_r, spu_nxt;
    logic [1:0]  dbg_r, dbg_nxt;
    logic        in_service_r, in_service_nxt;
    logic        fast_line_r, fast_line_nxt;
    logic        normal_line_r, normal_line_nxt;
    logic        eoh_r, eoh_nxt;
    logic [31:0] active;
    logic [31:0] smask;
    logic        fast_req, normal_req, nvec_ack;
    logic        ar_fire, r_nvec;

    always_comb begin
        smask      = strb_mask(wstrb_r);
        enable_nxt = (enable_r | (w_en ? wr_bits : 32'h0000_0000))
                     & ~(w_dis ? wr_bits : 32'h0000_0000);
        // source activity is ORed last so a new event beats a clear in the same cycle
        pending_nxt = (pending_r & ~(w_clr ? wr_bits : 32'h0000_0000))
                      | (w_set ? wr_bits : 32'h0000_0000)
                      | src_level_i;
        ffe_nxt = ((ffe_r | (w_ffen ? wr_bits : 32'h0000_0000))
                   & ~(w_ffdis ? wr_bits : 32'h0000_0000)) & `ICR_FF_VALID;
        spu_nxt = w_spu ? ((spu_r & ~smask) | (wdata_r & smask)) : spu_r;
        dbg_nxt = w_dbg ? ((dbg_r & ~smask[1:0]) | (wdata_r[1:0] & smask[1:0])) : dbg_r;
        active   = pending_r & enable_r;
        // source 0 is always fast; others go fast only when routed
        fast_req   = active[`ICR_BIT_FAST_SRC] | (|(active & ffe_r));
        normal_req = (|(active & ~ffe_r & `ICR_FF_VALID)) & ~in_service_r;
        fast_line_nxt   = fast_req & ~dbg_r[`ICR_BIT_GLOBAL_LINE_MASK];
        normal_line_nxt = normal_req & ~dbg_r[`ICR_BIT_GLOBAL_LINE_MASK];
        // in protection mode a debugger read of the vector has no side effect;
        // software acknowledges by writing the vector register instead
        nvec_ack = dbg_r[`ICR_BIT_PROTECTION_ENABLE] ? w_nvec : (ar_fire & r_nvec);
        in_service_nxt = in_service_r;
        if (w_eoh) begin
            in_service_nxt = 1'b0;
        end
        if (nvec_ack & normal_line_r) begin
            in_service_nxt = 1'b1;
        end
        eoh_nxt = w_eoh;
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            enable_r      <= `ICR_SRC_RST;
            pending_r     <= `ICR_SRC_RST;
            ffe_r         <= `ICR_SRC_RST;
            spu_r         <= `ICR_SPU_RST;
            dbg_r         <= `ICR_DBG_RST;
            in_service_r  <= 1'b0;
            fast_line_r   <= 1'b0;
            normal_line_r <= 1'b0;
            eoh_r         <= 1'b0;
        end else begin
            enable_r      <= enable_nxt;
            pending_r     <= pending_nxt;
            ffe_r         <= ffe_nxt;
            spu_r         <= spu_nxt;
            dbg_r         <= dbg_nxt;
            in_service_r  <= in_service_nxt;
            fast_line_r   <= fast_line_nxt;
            normal_line_r <= normal_line_nxt;
            eoh_r         <= eoh_nxt;
        end
    end

    // ---------------- read channel
    logic          arready_r, arready_nxt;
    logic          rvalid_r, rvalid_nxt;
    logic [31:0]   rdata_r, rdata_nxt;
    logic [1:0]    rresp_r, rresp_nxt;
    logic [31:0]   rd_val;
    logic          r_core, r_dbg;

    always_comb begin
        ar_fire = s_axi_arvalid_i & arready_r;
        r_nvec  = hit(s_axi_araddr_i, `ICR_OFF_NVEC);
        r_core  = hit(s_axi_araddr_i, `ICR_OFF_CORE);
        r_dbg   = hit(s_axi_araddr_i, `ICR_OFF_DBG);
        rd_val  = 32'h0000_0000;
        if (r_nvec) begin
            rd_val = normal_line_r ? normal_vector_i : spu_r;
        end else if (hit(s_axi_araddr_i, `ICR_OFF_FVEC)) begin
            rd_val = fast_line_r ? fast_vector_i : spu_r;
        end else if (hit(s_axi_araddr_i, `ICR_OFF_PEND)) begin
            rd_val = pending_r;
        end else if (hit(s_axi_araddr_i, `ICR_OFF_MASK)) begin
            rd_val = enable_r;
        end else if (r_core) begin
            rd_val[`ICR_BIT_FAST_LINE] = fast_line_r;
            rd_val[`ICR_BIT_NORM_LINE] = normal_line_r;
        end else if (hit(s_axi_araddr_i, `ICR_OFF_SPU)) begin
            rd_val = spu_r;
        end else if (r_dbg) begin
            rd_val[1:0] = dbg_r;
        end else if (hit(s_axi_araddr_i, `ICR_OFF_FFSTAT)) begin
            rd_val = ffe_r;
        end
        rvalid_nxt  = ar_fire | (rvalid_r & ~s_axi_rready_i);
        arready_nxt = ~rvalid_nxt;
        rdata_nxt   = ar_fire ? rd_val : rdata_r;
        rresp_nxt   = rresp_r;
        if (ar_fire) begin
            rresp_nxt = known(s_axi_araddr_i) ? icr_pkg::icr_resp_okay : icr_pkg::icr_resp_slverr;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= icr_pkg::icr_resp_okay;
        end else begin
            arready_r <= arready_nxt;
            rvalid_r  <= rvalid_nxt;
            rdata_r   <= rdata_nxt;
            rresp_r   <= rresp_nxt;
        end
    end

    assign s_axi_awready_o       = awready_r;
    assign s_axi_wready_o        = wready_r;
    assign s_axi_bvalid_o        = bvalid_r;
    assign s_axi_bresp_o         = bresp_r;
    assign s_axi_arready_o       = arready_r;
    assign s_axi_rvalid_o        = rvalid_r;
    assign s_axi_rdata_o         = rdata_r;
    assign s_axi_rresp_o         = rresp_r;
    assign fast_request_line_o   = fast_line_r;
    assign normal_request_line_o = normal_line_r;
    assign end_of_handling_o     = eoh_r;
    assign protection_enable_o   = dbg_r[`ICR_BIT_PROTECTION_ENABLE];

    // ---------------- checks
    logic r_fvec;
    assign r_fvec = hit(s_axi_araddr_i, `ICR_OFF_FVEC);

    sequence fast_cause_s;
        (|(pending_r & enable_r & ffe_r)) && !dbg_r[`ICR_BIT_GLOBAL_LINE_MASK];
    endsequence

    sequence eoh_write_s;
        w_eoh && !nvec_ack;
    endsequence

    core_fast_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ar_fire && r_core) |=> (s_axi_rdata_o[0] == $past(fast_line_r)))
        else $error("core status bit 0 does not match fast line");

    core_normal_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ar_fire && r_core) |=> (s_axi_rdata_o[1] == $past(normal_line_r)) && s_axi_rvalid_o)
        else $error("core status bit 1 does not match normal line");

    enable_cmd_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        w_en |=> ((enable_r & $past(wr_bits)) == $past(wr_bits)))
        else $error("enable command missed a source");

    disable_cmd_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        w_dis |=> ((enable_r & $past(wr_bits)) == 32'h0000_0000))
        else $error("disable command missed a source");

    pend_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (w_clr && (src_level_i == 32'h0000_0000)) |=> ((pending_r & $past(wr_bits)) == 32'h0000_0000))
        else $error("clear command left a source pending");

    pend_set_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        w_set |=> ((pending_r & $past(wr_bits)) == $past(wr_bits)))
        else $error("set command did not raise pending");

    eoh_release_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        eoh_write_s |=> end_of_handling_o && !in_service_r ##1 !end_of_handling_o || $past(w_eoh))
        else $error("end of handling write did not release service");

    spurious_read_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ar_fire && r_nvec && !normal_line_r) |=> (s_axi_rdata_o == $past(spu_r)))
        else $error("normal vector read did not give spurious value");

    spurious_fast_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ar_fire && r_fvec && !fast_line_r) |=> (s_axi_rdata_o == $past(spu_r)))
        else $error("fast vector read did not give spurious value");

    mask_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        dbg_r[`ICR_BIT_GLOBAL_LINE_MASK] [*2] |-> !fast_request_line_o && !normal_request_line_o)
        else $error("request line active under general mask");

    ff_bit0_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !ffe_r[0])
        else $error("fast route bit 0 became set");

    fast_route_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        fast_cause_s |=> fast_request_line_o)
        else $error("fast routed source did not raise fast line");

    dbg_rsvd_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ar_fire && (r_dbg || r_core)) |=> (s_axi_rdata_o[31:2] == 30'h0000_0000))
        else $error("undefined bits read nonzero");

    // a master may stall its ready, so each answer must stand until it is taken
    rdata_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (s_axi_rvalid_o && !s_axi_rready_i) |=> (s_axi_rvalid_o && $stable(s_axi_rdata_o)))
        else $error("read answer changed before it was taken");

    bresp_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (s_axi_bvalid_o && !s_axi_bready_i) |=> (s_axi_bvalid_o && $stable(s_axi_bresp_o)))
        else $error("write answer changed before it was taken");

    write_refuse_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        s_axi_bvalid_o |-> (!s_axi_awready_o && !s_axi_wready_o))
        else $error("write accepted while a response is open");

    read_refuse_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        s_axi_rvalid_o |-> !s_axi_arready_o)
        else $error("read accepted while read data is open");

    pend_read_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ar_fire && hit(s_axi_araddr_i, `ICR_OFF_PEND)) |=> (s_axi_rdata_o == $past(pending_r)))
        else $error("pending readout differs from pending sources");

    mask_read_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ar_fire && hit(s_axi_araddr_i, `ICR_OFF_MASK)) |=> (s_axi_rdata_o == $past(enable_r)))
        else $error("mask readout differs from enabled sources");

    ffstat_read_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ar_fire && hit(s_axi_araddr_i, `ICR_OFF_FFSTAT)) |=> (s_axi_rdata_o == $past(ffe_r)))
        else $error("fast route status differs from routing");

    fast_vec_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ar_fire && r_fvec && fast_line_r) |=> (s_axi_rdata_o == $past(fast_vector_i)))
        else $error("fast vector read did not give the fast vector");

    service_take_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ar_fire && r_nvec && normal_line_r && !dbg_r[`ICR_BIT_PROTECTION_ENABLE]) |=> in_service_r)
        else $error("normal vector read did not start service");

    protection_enable_read_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (ar_fire && dbg_r[`ICR_BIT_PROTECTION_ENABLE] && !w_nvec && !in_service_r) |=> !in_service_r)
        else $error("read in protection mode started service");

    service_gate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        in_service_r |=> !normal_request_line_o)
        else $error("normal line active while in service");

    eoh_pulse_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        end_of_handling_o |=> !end_of_handling_o)
        else $error("end of handling pulse longer than one cycle");

    dbg_write_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (w_dbg && wstrb_r[0]) |=> (protection_enable_o == $past(wdata_r[`ICR_BIT_PROTECTION_ENABLE])))
        else $error("protection bit did not follow the debug write");

endmodule : icr_top

/* File: tb/icr_core_model.sv */
`timescale 1ns/1ps
module icr_core_model (
    // clock
    input  wire logic clk_i,
    // request lines from the controller, active high
    input  wire logic fast_request_line_i,
    input  wire logic normal_request_line_i,
    // exception entries taken by the core
    output int        fast_entries_o,
    output int        normal_entries_o
);
    logic fast_q;
    logic norm_q;

    initial begin
        fast_q = 1'b0;
        norm_q = 1'b0;
        fast_entries_o = 0;
        normal_entries_o = 0;
    end

    // the core reacts to a line turning active, not to its level, so a held line counts once
    always @(posedge clk_i) begin
        if (fast_request_line_i && !fast_q) fast_entries_o <= fast_entries_o + 1;
        if (normal_request_line_i && !norm_q) normal_entries_o <= normal_entries_o + 1;
        fast_q <= fast_request_line_i;
        norm_q <= normal_request_line_i;
    end
endmodule : icr_core_model

/* File: tb/test_irq_ctrl_command_status_regs.sv */
`timescale 1ns/1ps
`include "icr_map.svh"
module test_irq_ctrl_command_status_regs;
    localparam logic [1:0] OK  = 2'h0;
    localparam logic [1:0] ERR = 2'h2;
    logic        clk_i     = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic [11:0] awaddr    = 12'h000;
    logic [11:0] araddr    = 12'h000;
    logic [31:0] wdata     = 32'h0;
    logic [31:0] src_level = 32'h0;
    logic [31:0] nvec      = 32'h0;
    logic [31:0] fvec      = 32'h0;
    logic [3:0]  wstrb     = 4'hF;
    logic        awvalid   = 1'b0;
    logic        wvalid    = 1'b0;
    logic        bready    = 1'b0;
    logic        arvalid   = 1'b0;
    logic        rready    = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        fast_line, norm_line, eoh, protection_enable;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata, m, p, sv;
    logic [33:0] re;
    logic [33:0] rq[$];
    logic [1:0]  bq[$];
    int          fails = 0;
    int          num_checks = 0;
    int          eoh_cnt = 0;
    int          fast_n, norm_n;

    always #5 clk_i = ~clk_i;

    icr_top dut_u (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .src_level_i(src_level), .normal_vector_i(nvec), .fast_vector_i(fvec),
        .fast_request_line_o(fast_line), .normal_request_line_o(norm_line),
        .end_of_handling_o(eoh), .protection_enable_o(protection_enable)
    );

    icr_core_model core_u (
        .clk_i(clk_i), .fast_request_line_i(fast_line), .normal_request_line_i(norm_line),
        .fast_entries_o(fast_n), .normal_entries_o(norm_n)
    );

    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task final_report;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : final_report

    // handshakes are judged at the falling edge: registered readies hold until the next rising edge
    always @(negedge clk_i) begin
        if (rvalid && rready) begin
            re = rq.pop_front();
            check(rdata, re[31:0]);
            check({30'h0, rresp}, {30'h0, re[33:32]});
        end
        if (bvalid && bready) check({30'h0, bresp}, {30'h0, bq.pop_front()});
        if (eoh) eoh_cnt++;
    end

    task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ah, wh, bh;
        bq.push_back(er);
        @(posedge clk_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge clk_i);
            ah = awvalid && awready;
            wh = wvalid && wready;
            bh = bvalid && bready;
            @(posedge clk_i);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
        end while (!bh);
        bready <= 1'b0;
    endtask : wr

    task rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ah, rh;
        rq.push_back({er, d});
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge clk_i);
            ah = arvalid && arready;
            rh = rvalid && rready;
            @(posedge clk_i);
            if (ah) arvalid <= 1'b0;
        end while (!rh);
        rready <= 1'b0;
    endtask : rd

    initial begin
        #200000;
        fails++;
        final_report();
    end

    initial begin
        void'($urandom(2));
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        nvec <= $urandom;
        fvec <= $urandom;
        rd(`ICR_OFF_SPU, 32'h0, OK);
        rd(`ICR_OFF_DBG, 32'h0, OK);
        rd(`ICR_OFF_CORE, 32'h0, OK);
        rd(`ICR_OFF_FFSTAT, 32'h0, OK);
        rd(`ICR_OFF_MASK, 32'h0, OK);
        rd(`ICR_OFF_PEND, 32'h0, OK);
        rd(12'h13C, 32'h0, ERR);
        wr(12'h13C, 32'hFFFF_FFFF, ERR);
        sv = $urandom;
        wr(`ICR_OFF_SPU, sv, OK);
        rd(`ICR_OFF_SPU, sv, OK);
        // only the strobed low byte may change
        wstrb <= 4'h1;
        wr(`ICR_OFF_SPU, 32'hFFFF_FFFF, OK);
        wstrb <= 4'hF;
        sv[7:0] = 8'hFF;
        rd(`ICR_OFF_SPU, sv, OK);
        wr(`ICR_OFF_DBG, 32'hFFFF_FFFF, OK);
        rd(`ICR_OFF_DBG, 32'h3, OK);
        check({31'h0, protection_enable}, 32'h1);
        wr(`ICR_OFF_DBG, 32'h0, OK);
        check({31'h0, protection_enable}, 32'h0);
        wr(`ICR_OFF_CORE, 32'hFFFF_FFFF, OK);
        rd(`ICR_OFF_CORE, 32'h0, OK);
        m = $urandom;
        p = $urandom;
        wr(`ICR_OFF_EN, m, OK);
        rd(`ICR_OFF_MASK, m, OK);
        wr(`ICR_OFF_EN, p, OK);
        rd(`ICR_OFF_MASK, m | p, OK);
        wr(`ICR_OFF_DIS, p, OK);
        rd(`ICR_OFF_MASK, m & ~p, OK);
        wr(`ICR_OFF_DIS, 32'hFFFF_FFFF, OK);
        rd(`ICR_OFF_MASK, 32'h0, OK);
        wr(`ICR_OFF_SET, p, OK);
        rd(`ICR_OFF_PEND, p, OK);
        wr(`ICR_OFF_CLR, m, OK);
        rd(`ICR_OFF_PEND, p & ~m, OK);
        wr(`ICR_OFF_CLR, 32'hFFFF_FFFF, OK);
        // a peripheral source on the normal line, taken, acknowledged and ended
        wr(`ICR_OFF_EN, 32'h20, OK);
        wr(`ICR_OFF_SET, 32'h20, OK);
        rd(`ICR_OFF_CORE, 32'h2, OK);
        check(norm_n, 32'h1);
        rd(`ICR_OFF_FVEC, sv, OK);
        wr(`ICR_OFF_DBG, 32'h1, OK);
        rd(`ICR_OFF_NVEC, nvec, OK);
        rd(`ICR_OFF_CORE, 32'h2, OK);
        wr(`ICR_OFF_DBG, 32'h0, OK);
        rd(`ICR_OFF_NVEC, nvec, OK);
        rd(`ICR_OFF_CORE, 32'h0, OK);
        p = eoh_cnt;
        wr(`ICR_OFF_EOH, $urandom, OK);
        rd(`ICR_OFF_CORE, 32'h2, OK);
        check(eoh_cnt, p + 1);
        // in protection mode a write to the vector offset takes the interrupt
        wr(`ICR_OFF_DBG, 32'h1, OK);
        wr(`ICR_OFF_NVEC, 32'h0, OK);
        rd(`ICR_OFF_CORE, 32'h0, OK);
        wr(`ICR_OFF_DBG, 32'h0, OK);
        wr(`ICR_OFF_EOH, 32'h0, OK);
        rd(`ICR_OFF_CORE, 32'h2, OK);
        wr(`ICR_OFF_CLR, 32'h20, OK);
        rd(`ICR_OFF_NVEC, sv, OK);
        // the dedicated fast source
        wr(`ICR_OFF_EN, 32'h1, OK);
        wr(`ICR_OFF_SET, 32'h1, OK);
        rd(`ICR_OFF_CORE, 32'h1, OK);
        rd(`ICR_OFF_FVEC, fvec, OK);
        wr(`ICR_OFF_CLR, 32'h1, OK);
        // a peripheral routed to the fast line, then masked and unrouted
        wr(`ICR_OFF_FFEN, 32'hFFFF_FFFF, OK);
        rd(`ICR_OFF_FFSTAT, 32'hFFFF_FFFE, OK);
        p = fast_n;
        wr(`ICR_OFF_EN, 32'h200, OK);
        wr(`ICR_OFF_SET, 32'h200, OK);
        rd(`ICR_OFF_CORE, 32'h1, OK);
        check(fast_n, p + 1);
        wr(`ICR_OFF_DBG, 32'h2, OK);
        rd(`ICR_OFF_CORE, 32'h0, OK);
        check({30'h0, fast_line, norm_line}, 32'h0);
        wr(`ICR_OFF_DBG, 32'h0, OK);
        wr(`ICR_OFF_FFDIS, 32'h200, OK);
        rd(`ICR_OFF_FFSTAT, 32'hFFFF_FDFE, OK);
        rd(`ICR_OFF_CORE, 32'h2, OK);
        wr(`ICR_OFF_CLR, 32'hFFFF_FFFF, OK);
        wr(`ICR_OFF_FFDIS, 32'hFFFF_FFFF, OK);
        // an active source level outlasts a clear command
        @(posedge clk_i);
        src_level <= 32'h8;
        repeat (3) @(posedge clk_i);
        wr(`ICR_OFF_CLR, 32'h8, OK);
        rd(`ICR_OFF_PEND, 32'h8, OK);
        @(posedge clk_i);
        src_level <= 32'h0;
        wr(`ICR_OFF_CLR, 32'h8, OK);
        rd(`ICR_OFF_PEND, 32'h0, OK);
        final_report();
    end
endmodule : test_irq_ctrl_command_status_regs
